// file: hdl/ptl_pkg.sv
// Constants and carrier types for the test, LED and miscellaneous register group
package ptl_pkg;

	// Register offsets on the management port
	localparam logic [7:0] ADDR_LED_DIRECT_CONTROL     = 8'h18;
	localparam logic [7:0] ADDR_SOFTWARE_RESET_CONTROL = 8'h1f;
	localparam logic [7:0] ADDR_FALSE_CARRIER_COUNTER  = 8'h42;
	localparam logic [7:0] ADDR_SELFTEST_BYTE_COUNT    = 8'h71;
	localparam logic [7:0] ADDR_SELFTEST_ERROR_COUNT   = 8'h72;
	localparam logic [7:0] ADDR_SELFTEST_PACKET_LENGTH = 8'h7b;
	localparam logic [7:0] ADDR_SELFTEST_PACKET_GAP    = 8'h7c;

	// Field positions
	localparam int BIT_ERR_LOCK       = 0;
	localparam int BIT_ERR_LOCK_CLEAR = 1;
	localparam int BIT_SW_RESET       = 15;
	localparam int BIT_LED_ENABLE     = 15;
	localparam int LSB_LED_PULSE      = 13;
	localparam int BIT_LED_FORCE_IRQ  = 12;
	localparam int LSB_LED_BLINK      = 8;
	localparam int LSB_LED_MODE       = 5;
	localparam int LSB_LED_POL        = 0;

	// Reset values
	localparam logic [15:0] RST_PACKET_LENGTH = 16'h05dc;
	localparam logic [15:0] RST_PACKET_GAP    = 16'h007d;
	localparam logic        RST_LED_ENABLE    = 1'b1;
	localparam logic [1:0]  RST_LED_PULSE     = 2'h2;
	localparam logic [1:0]  RST_LED_BLINK     = 2'h2;
	localparam logic [7:0]  RST_ERR_COUNT     = 8'h00;
	localparam logic [15:0] RST_BYTE_COUNT    = 16'h0000;
	localparam logic [7:0]  RST_FC_COUNT      = 8'h00;

	// Counter limits
	localparam logic [7:0]  MAX_ERR_COUNT  = 8'hff;
	localparam logic [15:0] MAX_BYTE_COUNT = 16'hffff;
	localparam logic [7:0]  MAX_FC_COUNT   = 8'hff;

	// Cycles after reset that load the straps; the synchroniser settles on the fourth, the fifth loads it
	localparam logic [2:0] STRAP_SETTLE = 3'h5;

	// LED pulse width codes
	typedef enum logic [1:0] {
		PTL_PULSE_50MS  = 2'h0,
		PTL_PULSE_100MS = 2'h1,
		PTL_PULSE_200MS = 2'h2,
		PTL_PULSE_500MS = 2'h3
	} ptl_pulse_t;

	// LED blink rate codes
	typedef enum logic [1:0] {
		PTL_BLINK_20HZ = 2'h0,
		PTL_BLINK_10HZ = 2'h1,
		PTL_BLINK_5HZ  = 2'h2,
		PTL_BLINK_2HZ  = 2'h3
	} ptl_blink_t;

	// LED mode codes
	typedef enum logic [1:0] {
		PTL_LED_MODE2 = 2'h0,
		PTL_LED_MODE1 = 2'h1,
		PTL_LED_MODE3 = 2'h2,
		PTL_LED_MODE_RSVD = 2'h3
	} ptl_led_mode_t;

	// LED configuration handed to the LED drive logic
	typedef struct packed {
		logic          enable;
		ptl_pulse_t    pulse;
		logic          force_irq;
		ptl_blink_t    blink;
		ptl_led_mode_t mode;
		logic [2:0]    pol;
	} ptl_led_cfg_t;

	// Strap pins sampled at reset
	typedef struct packed {
		logic [1:0] led_mode;
		logic [2:0] led_pol;
	} ptl_strap_t;

	// Management access strobes
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} ptl_mgmt_req_t;

endpackage

// file: hdl/ptl_sync3.sv
// Three-stage synchroniser that passes a change once the last two stages agree
`timescale 1ns/1ns
`default_nettype none

module ptl_sync3 #(
	parameter int W = 1
) (
	// Clock and control
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// First stage feeds only the second
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else if (ce) begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Per bit, accept a value only when stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					dout[i] <= 1'b0;
				end else if (ce && (s2[i] == s3[i])) begin
					dout[i] <= s3[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// file: hdl/ptl_regs.sv
// Self-test counters, packet settings, LED control, software reset and false-carrier counter
//
// Function
// (R1) Erroneous-byte count in low eight bits
// (R2) Single mode: error count stops at maximum
// (R3) Writing bit 0 locks self-test counters
// (R4) Writing bit 1 locks then clears counters
// (R5) Received-byte counter also locked by writes
// (R6) Continuous mode: wrap to zero, emit pulse
// (R7) Packet length register, resets to 1500
// (R8) Inter-packet gap register, resets to 125
// (R9) LED enable turns all LEDs on/off
// (R10) Pulse width selects 50-500 ms, default 200
// (R11) Blink rate selects 20-2 Hz, default 5
// (R12) Force bit asserts interrupt output unconditionally
// (R13) LED mode field, reset value from strap
// (R14) LED polarity bits, reset values from straps
// (R15) Software reset acts like hardware reset, self-clears
// (R16) Count error nibbles between idles at 100M
// (R17) Reading false-carrier counter returns and clears
// (R18) Reserved bits read zero, writes ignored
// (R19) False-carrier counter saturates at all ones
`timescale 1ns/1ns
`default_nettype none

module ptl_regs
	import ptl_pkg::*;
(
	// Clock, reset, enable
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	// Management register port
	input  wire ptl_mgmt_req_t mgmt_req,
	output var  logic [15:0]   mgmt_rdata,
	output var  logic          mgmt_rvalid,
	// Pattern checker events
	input  wire logic          chk_byte,
	input  wire logic          chk_err,
	input  wire logic          count_continuous,
	output var  logic          cnt_wrap,
	// Receive path events
	input  wire logic          speed_100,
	input  wire logic          bad_start_delimiter,
	// Straps (pins)
	input  wire ptl_strap_t    strap_on_reset,
	// Packet generator settings
	output var  logic [15:0]   pkt_length,
	output var  logic [15:0]   pkt_gap,
	// LED control
	input  wire logic [2:0]    led_ind,
	output var  ptl_led_cfg_t  led_cfg,
	output var  logic [2:0]    led_out,
	// Interrupt
	input  wire logic          irq_event,
	output var  logic          irq_out,
	// Device-wide software reset
	output var  logic          sw_reset
);

	logic         blk_rst;
	logic         wr_led;
	logic         wr_pdr;
	logic         wr_err;
	logic         rd_fc;
	logic         lock_req;
	logic         clear_req;
	ptl_strap_t   strap_sync;
	logic [2:0]   strap_cnt;
	logic [7:0]   err_run;
	logic [15:0]  byte_run;
	logic [7:0]   err_lock;
	logic [15:0]  byte_lock;
	logic [7:0]   fc_cnt;
	logic         err_max;
	logic         byte_max;
	logic [15:0]  next_rdata;

	// Software reset holds the block, except the strap synchroniser, in reset for one cycle
	assign blk_rst = !rst_n || sw_reset; // R15

	assign wr_led    = mgmt_req.wr && (mgmt_req.addr == ADDR_LED_DIRECT_CONTROL);
	assign wr_pdr    = mgmt_req.wr && (mgmt_req.addr == ADDR_SOFTWARE_RESET_CONTROL);
	assign wr_err    = mgmt_req.wr && (mgmt_req.addr == ADDR_SELFTEST_ERROR_COUNT);
	assign rd_fc     = mgmt_req.rd && (mgmt_req.addr == ADDR_FALSE_CARRIER_COUNTER);
	assign lock_req  = wr_err && (mgmt_req.wdata[BIT_ERR_LOCK] || mgmt_req.wdata[BIT_ERR_LOCK_CLEAR]); // R3 R4
	assign clear_req = wr_err && mgmt_req.wdata[BIT_ERR_LOCK_CLEAR]; // R4
	assign err_max   = (err_run == MAX_ERR_COUNT);
	assign byte_max  = (byte_run == MAX_BYTE_COUNT);

	// Strap pins cross in from outside
	ptl_sync3 #(
		.W($bits(ptl_strap_t))
	) u_strap_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.din   (strap_on_reset),
		.dout  (strap_sync)
	);

	// Settle window after reset during which straps load the LED fields
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			strap_cnt <= '0;
		end else if (ce && (strap_cnt != STRAP_SETTLE)) begin
			strap_cnt <= strap_cnt + 3'h1;
		end
	end

	// Software reset bit: set by write, clears itself the next cycle
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			sw_reset <= 1'b0;
		end else if (ce) begin
			sw_reset <= wr_pdr && mgmt_req.wdata[BIT_SW_RESET]; // R15
		end
	end

	// Running erroneous-byte counter
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			err_run <= RST_ERR_COUNT;
		end else if (ce) begin
			if (clear_req) begin
				err_run <= RST_ERR_COUNT; // R4
			end else if (chk_err) begin
				if (!err_max) begin // R2
					err_run <= err_run + 8'h01; // R1
				end else if (count_continuous) begin
					err_run <= RST_ERR_COUNT; // R6
				end
				// Single mode holds at the maximum
			end
		end
	end

	// Running received-byte counter
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			byte_run <= RST_BYTE_COUNT;
		end else if (ce) begin
			if (clear_req) begin
				byte_run <= RST_BYTE_COUNT; // R4
			end else if (chk_byte) begin
				if (!byte_max) begin
					byte_run <= byte_run + 16'h0001;
				end else if (count_continuous) begin
					byte_run <= RST_BYTE_COUNT; // R6
				end
			end
		end
	end

	// Locked copies that software reads
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			err_lock  <= RST_ERR_COUNT;
			byte_lock <= RST_BYTE_COUNT;
		end else if (ce && lock_req) begin
			err_lock  <= err_run; // R3
			byte_lock <= byte_run; // R5
		end
	end

	// One-cycle pulse when a counter wraps in continuous mode
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			cnt_wrap <= 1'b0;
		end else if (ce) begin
			cnt_wrap <= count_continuous && !clear_req && ((chk_err && err_max) || (chk_byte && byte_max)); // R6
		end
	end

	// Packet generator settings
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			pkt_length <= RST_PACKET_LENGTH; // R7
			pkt_gap    <= RST_PACKET_GAP; // R8
		end else if (ce && mgmt_req.wr) begin
			if (mgmt_req.addr == ADDR_SELFTEST_PACKET_LENGTH) begin
				pkt_length <= mgmt_req.wdata; // R7
			end
			if (mgmt_req.addr == ADDR_SELFTEST_PACKET_GAP) begin
				pkt_gap <= mgmt_req.wdata; // R8
			end
		end
	end

	// LED configuration fields
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			led_cfg.enable    <= RST_LED_ENABLE; // R9
			led_cfg.pulse     <= ptl_pulse_t'(RST_LED_PULSE); // R10
			led_cfg.force_irq <= 1'b0;
			led_cfg.blink     <= ptl_blink_t'(RST_LED_BLINK); // R11
			led_cfg.mode      <= PTL_LED_MODE2;
			led_cfg.pol       <= '0;
		end else if (ce) begin
			if (wr_led) begin
				led_cfg.enable    <= mgmt_req.wdata[BIT_LED_ENABLE]; // R9
				led_cfg.pulse     <= ptl_pulse_t'(mgmt_req.wdata[LSB_LED_PULSE +: 2]); // R10
				led_cfg.force_irq <= mgmt_req.wdata[BIT_LED_FORCE_IRQ]; // R12
				led_cfg.blink     <= ptl_blink_t'(mgmt_req.wdata[LSB_LED_BLINK +: 2]); // R11
				led_cfg.mode      <= ptl_led_mode_t'(mgmt_req.wdata[LSB_LED_MODE +: 2]); // R13
				led_cfg.pol       <= mgmt_req.wdata[LSB_LED_POL +: 3]; // R14
			end else if (strap_cnt != STRAP_SETTLE) begin
				// Straps define the power-up value of mode and polarities
				led_cfg.mode <= ptl_led_mode_t'(strap_sync.led_mode); // R13
				led_cfg.pol  <= strap_sync.led_pol; // R14
			end
		end
	end

	// LED pins: polarity applied per LED, disabled LEDs sit at their off level
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_led
			always_ff @(posedge mclk) begin
				if (blk_rst) begin
					led_out[g] <= 1'b0;
				end else if (ce) begin
					led_out[g] <= (led_cfg.enable && led_ind[g]) ~^ led_cfg.pol[g]; // R9 R14
				end
			end
		end
	endgenerate

	// Interrupt output, forced on while the force bit is set
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			irq_out <= 1'b0;
		end else if (ce) begin
			irq_out <= led_cfg.force_irq || irq_event; // R12
		end
	end

	// False-carrier counter; a nibble arriving during the clearing read is kept
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			fc_cnt <= RST_FC_COUNT;
		end else if (ce) begin
			if (rd_fc) begin
				fc_cnt <= (speed_100 && bad_start_delimiter) ? 8'h01 : RST_FC_COUNT; // R17
			end else if (speed_100 && bad_start_delimiter && (fc_cnt != MAX_FC_COUNT)) begin
				fc_cnt <= fc_cnt + 8'h01; // R16 R19
			end
		end
	end

	// Read data selection; reserved and unmapped bits read zero
	always_comb begin
		next_rdata = 16'h0000;
		case (mgmt_req.addr)
			ADDR_LED_DIRECT_CONTROL: begin
				next_rdata[BIT_LED_ENABLE]         = led_cfg.enable;
				next_rdata[LSB_LED_PULSE +: 2]     = led_cfg.pulse;
				next_rdata[BIT_LED_FORCE_IRQ]      = led_cfg.force_irq;
				next_rdata[LSB_LED_BLINK +: 2]     = led_cfg.blink;
				next_rdata[LSB_LED_MODE +: 2]      = led_cfg.mode;
				next_rdata[LSB_LED_POL +: 3]       = led_cfg.pol;
			end
			ADDR_SOFTWARE_RESET_CONTROL: begin
				next_rdata[BIT_SW_RESET] = sw_reset;
			end
			ADDR_FALSE_CARRIER_COUNTER: begin
				next_rdata[7:0] = fc_cnt; // R17
			end
			ADDR_SELFTEST_BYTE_COUNT: begin
				next_rdata = byte_lock; // R5
			end
			ADDR_SELFTEST_ERROR_COUNT: begin
				next_rdata[7:0] = err_lock; // R1 R18
			end
			ADDR_SELFTEST_PACKET_LENGTH: begin
				next_rdata = pkt_length;
			end
			ADDR_SELFTEST_PACKET_GAP: begin
				next_rdata = pkt_gap;
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (blk_rst) begin
			mgmt_rdata  <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end else if (ce) begin
			mgmt_rvalid <= mgmt_req.rd;
			if (mgmt_req.rd) begin
				mgmt_rdata <= next_rdata;
			end
		end
	end

endmodule

`default_nettype wire

// file: test/ptl_regs_properties.sv
// Port-level assertions for the test, LED and miscellaneous register group
`timescale 1ns/1ns
`default_nettype none

module ptl_regs_chk
	import ptl_pkg::*;
(
	// Clock and reset
	input wire logic          mclk,
	input wire logic          rst_n,
	input wire logic          ce,
	// Management port
	input wire ptl_mgmt_req_t mgmt_req,
	input wire logic [15:0]   mgmt_rdata,
	input wire logic          mgmt_rvalid,
	// Events
	input wire logic          chk_byte,
	input wire logic          chk_err,
	input wire logic          count_continuous,
	input wire logic          cnt_wrap,
	input wire logic          speed_100,
	input wire logic          bad_start_delimiter,
	// Outputs, LED indications and interrupt event
	input wire logic [15:0]   pkt_length,
	input wire logic [15:0]   pkt_gap,
	input wire logic [2:0]    led_ind,
	input wire ptl_led_cfg_t  led_cfg,
	input wire logic [2:0]    led_out,
	input wire logic          irq_event,
	input wire logic          irq_out,
	input wire logic          sw_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic rd;
	logic wr;
	logic run;
	assign rd = ce && mgmt_req.rd && !sw_reset;
	assign wr = ce && mgmt_req.wr && !sw_reset;
	assign run = ce && !sw_reset;
	sequence s_fcr;
		rd && mgmt_req.addr == 8'h42 && !(speed_100 && bad_start_delimiter);
	endsequence
	a_read_answer: assert property (rd |=> mgmt_rvalid) else $error("read not answered");
	a_length_write: assert property (wr && mgmt_req.addr == 8'h7b |=> pkt_length == $past(mgmt_req.wdata))
		else $error("packet length not written");
	a_gap_write: assert property (wr && mgmt_req.addr == 8'h7c |=> pkt_gap == $past(mgmt_req.wdata))
		else $error("packet gap not written");
	a_sw_reset_pulse: assert property (wr && mgmt_req.addr == 8'h1f && mgmt_req.wdata[15] |=>
		sw_reset ##1 (!sw_reset && pkt_length == 16'h05dc)) else $error("software reset wrong");
	a_force_irq: assert property (run && led_cfg.force_irq |=> irq_out) else $error("forced irq missing");
	a_led_drive: assert property (run |=> led_out == ~(({3{$past(led_cfg.enable)}} & $past(led_ind))
		^ $past(led_cfg.pol))) else $error("led output wrong");
	a_wrap_cause: assert property (cnt_wrap |-> $past(count_continuous) && $past(chk_err || chk_byte))
		else $error("wrap without cause");
	a_unmapped_zero: assert property (rd && !(mgmt_req.addr inside {8'h18, 8'h1f, 8'h42, 8'h71, 8'h72,
		8'h7b, 8'h7c}) |=> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
	a_reserved_zero: assert property (rd && mgmt_req.addr inside {8'h42, 8'h72} |=>
		mgmt_rdata[15:8] == 8'h00) else $error("reserved bits not zero");
	a_fc_clear: assert property (s_fcr ##1 s_fcr |=> mgmt_rdata == 16'h0000)
		else $error("false carrier not cleared");
	c_wrap: cover property (cnt_wrap);
	c_sw_reset: cover property (sw_reset);
	c_forced: cover property (irq_out && led_cfg.force_irq);
	c_fc_back: cover property (s_fcr ##1 s_fcr);
endmodule

bind ptl_regs ptl_regs_chk i_ptl_regs_chk (.*);

`default_nettype wire

// file: test/test_ptl_regs.sv
// Self-checking bench for the test, LED and miscellaneous register group
`timescale 1ns/1ns
`default_nettype none

module test_ptl_regs import ptl_pkg::*;;
	logic          mclk = 0;
	logic          rst_n = 0;
	logic          ce = 1;
	ptl_mgmt_req_t req = '0;
	logic [15:0]   rdata;
	logic          rvalid;
	logic          chk_byte = 0;
	logic          chk_err = 0;
	logic          count_continuous = 0;
	logic          cnt_wrap;
	logic          speed_100 = 0;
	logic          bad_start_delimiter = 0;
	ptl_strap_t    strap = '0;
	logic [15:0]   pkt_length;
	logic [15:0]   pkt_gap;
	logic [2:0]    led_ind = 0;
	ptl_led_cfg_t  led_cfg;
	logic [2:0]    led_out;
	logic          irq_event = 0;
	logic          irq_out;
	logic [15:0]   len;
	logic [15:0]   gap;
	logic [15:0]   d;
	logic [15:0]   led_rst;
	int            seed = 32'hd91d;
	int            n;
	int            m;
	int            fail_count = 0;
	int            tests_run = 0;

	ptl_regs i_ptl_regs (
		.mclk(mclk), .rst_n(rst_n), .ce(ce), .mgmt_req(req), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
		.chk_byte(chk_byte), .chk_err(chk_err), .count_continuous(count_continuous), .cnt_wrap(cnt_wrap),
		.speed_100(speed_100), .bad_start_delimiter(bad_start_delimiter), .strap_on_reset(strap),
		.pkt_length(pkt_length), .pkt_gap(pkt_gap), .led_ind(led_ind), .led_cfg(led_cfg),
		.led_out(led_out), .irq_event(irq_event), .irq_out(irq_out), .sw_reset()
	);

	always #5 mclk = ~mclk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Every bus task ends one idle cycle later so strobes are never re-raised in the same step
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		req = '{1'b1, 1'b0, a, v};
		@(posedge mclk);
		#1 req = '0;
		@(posedge mclk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		req = '{1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk);
		#1 req = '0;
		chk({15'h0000, rvalid}, 16'h0001);
		chk(rdata, exp);
		@(posedge mclk);
		#1;
	endtask

	task automatic ev(input int cnt, input logic e, input logic b, input logic f);
		chk_err = e;
		chk_byte = b;
		bad_start_delimiter = f;
		repeat (cnt) @(posedge mclk);
		#1 {chk_err, chk_byte, bad_start_delimiter} = 3'b000;
		@(posedge mclk);
		#1;
	endtask

	initial begin
		#200000;
		fail_count++;
		test_done;
	end

	initial begin
		strap = ptl_strap_t'(5'($random(seed)));
		repeat (10) @(posedge mclk);
		#1 rst_n = 1;
		repeat (6) @(posedge mclk);
		#1;
		led_rst = 16'hc200 | {9'h000, strap.led_mode, 2'b00, strap.led_pol};
		rd(8'h7b, 16'h05dc);
		rd(8'h7c, 16'h007d);
		rd(8'h18, led_rst);
		rd(8'h42, 16'h0000);
		rd(8'h72, 16'h0000);
		rd(8'h1f, 16'h0000);
		rd(8'h30, 16'h0000);
		len = 16'($random(seed));
		gap = 16'($random(seed));
		wr(8'h7b, len);
		wr(8'h7c, gap);
		wr(8'h30, 16'hffff);
		chk(pkt_length, len);
		chk(pkt_gap, gap);
		rd(8'h7c, gap);
		// Single mode: count, lock, keep counting behind the lock
		n = 1 + {$random(seed)} % 40;
		m = {$random(seed)} % 40;
		ev(n, 1, 1, 0);
		ev(m, 0, 1, 0);
		wr(8'h72, 16'h0001);
		ev(5, 1, 1, 0);
		rd(8'h72, n[15:0]);
		rd(8'h71, n[15:0] + m[15:0]);
		ev(300, 1, 0, 0);
		wr(8'h72, 16'h0001);
		rd(8'h72, 16'h00ff);
		wr(8'h72, 16'h0002);
		wr(8'h72, 16'h0001);
		rd(8'h72, 16'h0000);
		rd(8'h71, 16'h0000);
		// Clock enable low: events must leave the cleared counters alone
		ce = 0;
		ev(20, 1, 1, 0);
		ce = 1;
		count_continuous = 1;
		ev(255, 1, 1, 0);
		{chk_err, chk_byte} = 2'b11;
		@(posedge mclk);
		#1 {chk_err, chk_byte} = 2'b00;
		chk({15'h0000, cnt_wrap}, 16'h0001);
		@(posedge mclk);
		#1 chk({15'h0000, cnt_wrap}, 16'h0000);
		wr(8'h72, 16'h0001);
		rd(8'h72, 16'h0000);
		rd(8'h71, 16'h0100);
		count_continuous = 0;
		// False carrier: back-to-back reads, saturation, speed gating
		speed_100 = 1;
		n = 1 + {$random(seed)} % 50;
		ev(n, 0, 0, 1);
		req = '{1'b0, 1'b1, 8'h42, 16'h0000};
		@(posedge mclk);
		#1 chk(rdata, n[15:0]);
		@(posedge mclk);
		#1 req = '0;
		chk(rdata, 16'h0000);
		ev(300, 0, 0, 1);
		rd(8'h42, 16'h00ff);
		speed_100 = 0;
		ev(9, 0, 0, 1);
		rd(8'h42, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			d = 16'($random(seed));
			d[15] = i[0];
			d[12] = i[1];
			led_ind = 3'($random(seed));
			irq_event = 1'($random(seed));
			wr(8'h18, d & 16'hf367);
			chk({13'h0000, led_out}, {13'h0000, ~(({3{d[15]}} & led_ind) ^ d[2:0])});
			chk({15'h0000, irq_out}, {15'h0000, d[12] | irq_event});
			rd(8'h18, d & 16'hf367);
		end
		wr(8'h7b, 16'h1234);
		wr(8'h1f, 16'h8000);
		repeat (5) @(posedge mclk);
		#1;
		rd(8'h7b, 16'h05dc);
		rd(8'h18, led_rst);
		rd(8'h1f, 16'h0000);
		test_done;
	end
endmodule

`default_nettype wire
